/* File: core/dma_map.svh */
/*
  Register map, field positions, reset values and fixed sizes of the DMA block.
  Assumes byte addressing on a 32-bit Avalon-MM slave, one aligned word per register.
*/
// Summary of operation
// - Global enable bit: 0 stops the controller, 1 lets it run; set before use.
// - With global enable 0, channel register writes are dropped and reads return zero.
// - Each channel has a 32-bit read/write source pointer, reset to zero.
// - Setting channel enable makes the channel run from the values written so far.
// - During a transfer the source pointer steps as each element moves, only when its control advance bit is 1.
// - Each channel has a 32-bit read/write destination pointer, reset to zero.
// - Control bit chooses whether the destination pointer advances (1) or stays (0).
`ifndef DMA_MAP_SVH
`define DMA_MAP_SVH

`define DMA_NUM_CH         2
`define DMA_CH_IDX_W       1
`define DMA_CH_IDX_LSB     5
`define DMA_ADDR_W         12

`define DMA_GCFG_OFS       12'h000
`define DMA_STAT_OFS       12'h004
`define DMA_CH_PAGE        4'h1

`define DMA_SRC_OFS        5'h00
`define DMA_DST_OFS        5'h04
`define DMA_CTRL_OFS       5'h0c
`define DMA_SETUP_OFS      5'h10

`define DMA_SEL_SRC        2'h0
`define DMA_SEL_DST        2'h1
`define DMA_SEL_CTRL       2'h2
`define DMA_SEL_SETUP      2'h3

`define DMA_GCFG_EN_BIT    0
`define DMA_GCFG_RES_BIT   1

`define DMA_CTRL_CNT_LSB   0
`define DMA_CTRL_CNT_W     12
`define DMA_CTRL_CNT_MASK  32'h00000fff
`define DMA_CTRL_SW_LSB    18
`define DMA_CTRL_DW_LSB    21
`define DMA_CTRL_SI_BIT    26
`define DMA_CTRL_DI_BIT    27
`define DMA_CTRL_WMASK     32'h8cffffff

`define DMA_SETUP_EN_BIT   0

`define DMA_ADDR_RST       32'h00000000
`define DMA_CTRL_RST       32'h00000000

`endif

/* File: core/dma_pkg.sv */
/*
  Types and small helpers shared by the DMA block.
  Assumes nothing of its surroundings.
*/
package dma_pkg;

  typedef enum logic [2:0] {
    WIDTH_BYTE = 3'b000,
    WIDTH_HALF = 3'b001,
    WIDTH_WORD = 3'b010
  } xfer_width_t;

  typedef enum logic [1:0] {
    MV_IDLE  = 2'b00,
    MV_READ  = 2'b01,
    MV_WRITE = 2'b10,
    MV_DONE  = 2'b11
  } mover_state_t;

  // Reserved width codes are treated as bytes so a bad setting never skips memory.
  function automatic logic [2:0] width_bytes(input logic [2:0] w);
    width_bytes = (w == WIDTH_WORD) ? 3'h4 : (w == WIDTH_HALF) ? 3'h2 : 3'h1;
  endfunction : width_bytes

  function automatic logic [31:0] width_data_mask(input logic [2:0] w);
    width_data_mask = (w == WIDTH_WORD) ? 32'hffffffff : (w == WIDTH_HALF) ? 32'h0000ffff : 32'h000000ff;
  endfunction : width_data_mask

  function automatic logic [3:0] lane_mask(input logic [2:0] w, input logic [1:0] a);
    lane_mask = (w == WIDTH_WORD) ? 4'hf : (w == WIDTH_HALF) ? (4'h3 << {a[1], 1'b0}) : (4'h1 << a);
  endfunction : lane_mask

  function automatic logic misaligned(input logic [2:0] w, input logic [1:0] a);
    misaligned = ((w == WIDTH_HALF) & a[0]) | ((w == WIDTH_WORD) & (|a));
  endfunction : misaligned

endpackage : dma_pkg

/* File: core/dma_channel_ctx.sv */
/*
  One channel's pointers, control word and enable.
  Assumes writes arrive already decoded and masked by byte lane, and that steps come from the mover.
*/
`timescale 1ns/1ps
`default_nettype none
`include "dma_map.svh"

module dma_channel_ctx
  import dma_pkg::*;
(
  input  wire logic        i_clk_sys,
  input  wire logic        i_rstn,
  input  wire logic        i_wr_en,
  input  wire logic [1:0]  i_wr_sel,
  input  wire logic [31:0] i_wr_data,
  input  wire logic [31:0] i_wr_mask,
  input  wire logic        i_step,
  output logic      [31:0] o_src,
  output logic      [31:0] o_dst,
  output logic      [31:0] o_ctrl,
  output logic             o_enable,
  output logic             o_pending
);

  logic [31:0] src_reg;
  logic [31:0] src_next;
  logic [31:0] dst_reg;
  logic [31:0] dst_next;
  logic [31:0] ctrl_reg;
  logic [31:0] ctrl_next;
  logic        en_reg;
  logic        en_next;

  wire         wr_src   = i_wr_en & (i_wr_sel == `DMA_SEL_SRC);
  wire         wr_dst   = i_wr_en & (i_wr_sel == `DMA_SEL_DST);
  wire         wr_ctrl  = i_wr_en & (i_wr_sel == `DMA_SEL_CTRL);
  wire         wr_setup = i_wr_en & (i_wr_sel == `DMA_SEL_SETUP) & i_wr_mask[`DMA_SETUP_EN_BIT];
  wire [2:0]   src_w    = ctrl_reg[`DMA_CTRL_SW_LSB +: 3];
  wire [2:0]   dst_w    = ctrl_reg[`DMA_CTRL_DW_LSB +: 3];
  wire [31:0]  src_inc  = {29'h0, width_bytes(src_w)};
  wire [31:0]  dst_inc  = {29'h0, width_bytes(dst_w)};
  wire         src_adv  = i_step & ctrl_reg[`DMA_CTRL_SI_BIT];
  wire         dst_adv  = i_step & ctrl_reg[`DMA_CTRL_DI_BIT];
  wire [11:0]  count    = ctrl_reg[`DMA_CTRL_CNT_LSB +: `DMA_CTRL_CNT_W];
  wire [11:0]  count_dec = count - 12'h001;
  wire [31:0]  src_wr   = (src_reg & ~i_wr_mask) | (i_wr_data & i_wr_mask);
  wire [31:0]  dst_wr   = (dst_reg & ~i_wr_mask) | (i_wr_data & i_wr_mask);
  wire [31:0]  ctrl_wr  = ((ctrl_reg & ~i_wr_mask) | (i_wr_data & i_wr_mask)) & `DMA_CTRL_WMASK;
  wire [31:0]  ctrl_dec = (ctrl_reg & ~`DMA_CTRL_CNT_MASK) | {20'h0, count_dec};

  // A software write wins over a step; software must not write while a channel runs anyway.
  assign src_next  = wr_src ? src_wr : src_adv ? (src_reg + src_inc) : src_reg;
  assign dst_next  = wr_dst ? dst_wr : dst_adv ? (dst_reg + dst_inc) : dst_reg;
  assign ctrl_next = wr_ctrl ? ctrl_wr : i_step ? ctrl_dec : ctrl_reg;
  // The enable drops by itself once the element count is spent.
  assign en_next   = wr_setup ? i_wr_data[`DMA_SETUP_EN_BIT] : (en_reg & (count == 12'h000)) ? 1'b0 : en_reg;

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      src_reg  <= `DMA_ADDR_RST;
      dst_reg  <= `DMA_ADDR_RST;
      ctrl_reg <= `DMA_CTRL_RST;
      en_reg   <= 1'b0;
    end else begin
      src_reg  <= src_next;
      dst_reg  <= dst_next;
      ctrl_reg <= ctrl_next;
      en_reg   <= en_next;
    end
  end

  assign o_src     = src_reg;
  assign o_dst     = dst_reg;
  assign o_ctrl    = ctrl_reg;
  assign o_enable  = en_reg;
  // The channel runs straight from its live registers, so enabling picks up what was written.
  assign o_pending = en_reg & (count != 12'h000);

endmodule : dma_channel_ctx
`default_nettype wire

/* File: core/dma_mover.sv */
/*
  Moves one element per start: a read from the source, then a write to the destination.
  Assumes an Avalon-MM memory master port on the same clock and stable pointers until o_step.
*/
`timescale 1ns/1ps
`default_nettype none
`include "dma_map.svh"

module dma_mover
  import dma_pkg::*;
(
  input  wire logic        i_clk_sys,
  input  wire logic        i_rstn,
  input  wire logic        i_start,
  input  wire logic [31:0] i_src,
  input  wire logic [31:0] i_dst,
  input  wire logic [2:0]  i_src_w,
  input  wire logic [2:0]  i_dst_w,
  input  wire logic [31:0] i_m_readdata,
  input  wire logic        i_m_waitrequest,
  output logic             o_busy,
  output logic             o_step,
  output logic      [31:0] o_m_address,
  output logic             o_m_read,
  output logic             o_m_write,
  output logic      [31:0] o_m_writedata,
  output logic      [3:0]  o_m_byteenable
);

  mover_state_t state_reg;
  logic         step_reg;
  logic [31:0]  addr_reg;
  logic         rd_reg;
  logic         wr_reg;
  logic [31:0]  wdata_reg;
  logic [3:0]   be_reg;

  wire [31:0] rd_shift = i_m_readdata >> {i_src[1:0], 3'b000};
  wire [31:0] element  = rd_shift & width_data_mask(i_src_w);
  wire [31:0] wr_word  = element << {i_dst[1:0], 3'b000};
  wire        bus_done = ~i_m_waitrequest;

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      state_reg <= MV_IDLE;
      step_reg  <= 1'b0;
      addr_reg  <= 32'h00000000;
      rd_reg    <= 1'b0;
      wr_reg    <= 1'b0;
      wdata_reg <= 32'h00000000;
      be_reg    <= 4'h0;
    end else begin
      unique case (state_reg)
        MV_IDLE: begin
          step_reg <= 1'b0;
          if (i_start) begin
            addr_reg  <= {i_src[31:2], 2'b00};
            be_reg    <= lane_mask(i_src_w, i_src[1:0]);
            rd_reg    <= 1'b1;
            state_reg <= MV_READ;
          end
        end
        MV_READ: begin
          if (bus_done) begin
            rd_reg    <= 1'b0;
            addr_reg  <= {i_dst[31:2], 2'b00};
            be_reg    <= lane_mask(i_dst_w, i_dst[1:0]);
            wdata_reg <= wr_word;
            wr_reg    <= 1'b1;
            state_reg <= MV_WRITE;
          end
        end
        MV_WRITE: begin
          if (bus_done) begin
            wr_reg    <= 1'b0;
            step_reg  <= 1'b1;
            state_reg <= MV_DONE;
          end
        end
        MV_DONE: begin
          step_reg  <= 1'b0;
          state_reg <= MV_IDLE;
        end
      endcase
    end
  end

  assign o_busy         = (state_reg != MV_IDLE);
  assign o_step         = step_reg;
  assign o_m_address    = addr_reg;
  assign o_m_read       = rd_reg;
  assign o_m_write      = wr_reg;
  assign o_m_writedata  = wdata_reg;
  assign o_m_byteenable = be_reg;

endmodule : dma_mover
`default_nettype wire

/* File: core/dma_global_enable_and_channel_addresses.sv */
/*
  Top of the DMA block: global enable, register slave, channel arbitration and the element mover.
  Assumes a 32-bit Avalon-MM master for software access and an Avalon-MM memory slave
  behind the mover port, all on i_clk_sys.
*/
// Decided for this implementation: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
`include "dma_map.svh"

module dma_global_enable_and_channel_addresses
  import dma_pkg::*;
(
  input  wire logic                   i_clk_sys,
  input  wire logic                   i_rstn,
  input  wire logic [`DMA_ADDR_W-1:0] i_avs_address,
  input  wire logic                   i_avs_read,
  input  wire logic                   i_avs_write,
  input  wire logic [31:0]            i_avs_writedata,
  input  wire logic [3:0]             i_avs_byteenable,
  output logic      [31:0]            o_avs_readdata,
  output logic                        o_avs_waitrequest,
  output logic      [31:0]            o_m_address,
  output logic                        o_m_read,
  output logic                        o_m_write,
  output logic      [31:0]            o_m_writedata,
  output logic      [3:0]             o_m_byteenable,
  input  wire logic [31:0]            i_m_readdata,
  input  wire logic                   i_m_waitrequest,
  output logic                        o_dma_enable,
  output logic      [`DMA_NUM_CH-1:0] o_ch_enable
);

  localparam int NCH = `DMA_NUM_CH;
  localparam int CW  = `DMA_CH_IDX_W;

  logic          gen_reg;
  logic          gen_next;
  logic          gres_reg;
  logic          gres_next;
  logic          waitreq_reg;
  logic          waitreq_next;
  logic [31:0]   rdata_reg;
  logic [31:0]   rdata_next;
  logic          start_reg;
  logic          start_next;
  logic [CW-1:0] cur_reg;
  logic [CW-1:0] cur_next;

  logic [31:0]   src_arr  [0:NCH-1];
  logic [31:0]   dst_arr  [0:NCH-1];
  logic [31:0]   ctrl_arr [0:NCH-1];
  logic [NCH-1:0] ch_en;
  logic [NCH-1:0] ch_pend;
  logic [NCH-1:0] src_mis;
  logic [NCH-1:0] dst_mis;
  logic [NCH-1:0] ch_step;

  logic          mv_busy;
  logic          mv_step;
  logic          pick_valid;
  logic [CW-1:0] pick_num;

  // Bus decode. A transfer completes on the edge where the request meets waitrequest low.
  wire        req        = i_avs_read | i_avs_write;
  wire        accept     = req & ~waitreq_reg;
  wire        wr_take    = accept & i_avs_write;
  wire        hit_gcfg   = (i_avs_address == `DMA_GCFG_OFS);
  wire        hit_stat   = (i_avs_address == `DMA_STAT_OFS);
  wire        hit_page   = (i_avs_address[`DMA_ADDR_W-1:8] == `DMA_CH_PAGE);
  wire [2:0]  ch_field   = i_avs_address[7:5];
  wire [CW-1:0] ch_num   = i_avs_address[`DMA_CH_IDX_LSB +: CW];
  wire        ch_ok      = (ch_field < 3'(NCH));
  wire [4:0]  ch_ofs     = i_avs_address[4:0];
  wire        sel_src    = (ch_ofs == `DMA_SRC_OFS);
  wire        sel_dst    = (ch_ofs == `DMA_DST_OFS);
  wire        sel_ctrl   = (ch_ofs == `DMA_CTRL_OFS);
  wire        sel_setup  = (ch_ofs == `DMA_SETUP_OFS);
  wire        hit_ch     = hit_page & ch_ok & (sel_src | sel_dst | sel_ctrl | sel_setup);
  wire [1:0]  ch_sel     = sel_dst ? `DMA_SEL_DST : sel_ctrl ? `DMA_SEL_CTRL :
                           sel_setup ? `DMA_SEL_SETUP : `DMA_SEL_SRC;
  // Only the global register stays reachable while the controller is stopped.
  wire        regs_open  = gen_reg;
  wire        ch_wr      = wr_take & hit_ch & regs_open;
  wire [31:0] wr_mask    = {{8{i_avs_byteenable[3]}}, {8{i_avs_byteenable[2]}},
                            {8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};
  wire        gcfg_wr    = wr_take & hit_gcfg & i_avs_byteenable[0];

  // Read selection. While stopped, everything but the global register reads as zero, as do unmapped addresses.
  wire [31:0] gcfg_word  = {30'h0, gres_reg, gen_reg};
  wire [31:0] stat_word  = {mv_busy, 7'h00, 8'(dst_mis), 8'(src_mis), 8'(ch_en)};
  wire [31:0] setup_word = {31'h0, ch_en[ch_num]};
  wire [31:0] ch_word    = sel_src ? src_arr[ch_num] : sel_dst ? dst_arr[ch_num] :
                           sel_ctrl ? ctrl_arr[ch_num] : setup_word;
  wire [31:0] rd_value   = hit_gcfg ? gcfg_word :
                           (hit_stat & regs_open) ? stat_word :
                           (hit_ch & regs_open) ? ch_word : 32'h00000000;

  // One wait cycle per access keeps the read mux out of the master's path.
  assign waitreq_next = ~(req & waitreq_reg);
  assign rdata_next   = (req & waitreq_reg & i_avs_read) ? rd_value : rdata_reg;
  // Bit 1 is stored as written; software is expected to keep it and the upper bits zero.
  assign gen_next     = gcfg_wr ? i_avs_writedata[`DMA_GCFG_EN_BIT] : gen_reg;
  assign gres_next    = gcfg_wr ? i_avs_writedata[`DMA_GCFG_RES_BIT] : gres_reg;

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      gen_reg     <= 1'b0;
      gres_reg    <= 1'b0;
      waitreq_reg <= 1'b1;
      rdata_reg   <= 32'h00000000;
    end else begin
      gen_reg     <= gen_next;
      gres_reg    <= gres_next;
      waitreq_reg <= waitreq_next;
      rdata_reg   <= rdata_next;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : g_ch
      dma_channel_ctx u_ch (
        .i_clk_sys (i_clk_sys),
        .i_rstn    (i_rstn),
        .i_wr_en   (ch_wr & (ch_num == CW'(g))),
        .i_wr_sel  (ch_sel),
        .i_wr_data (i_avs_writedata),
        .i_wr_mask (wr_mask),
        .i_step    (ch_step[g]),
        .o_src     (src_arr[g]),
        .o_dst     (dst_arr[g]),
        .o_ctrl    (ctrl_arr[g]),
        .o_enable  (ch_en[g]),
        .o_pending (ch_pend[g])
      );
      // Misalignment is only reported; the element still moves on the lanes the low bits pick.
      assign src_mis[g] = misaligned(ctrl_arr[g][`DMA_CTRL_SW_LSB +: 3], src_arr[g][1:0]);
      assign dst_mis[g] = misaligned(ctrl_arr[g][`DMA_CTRL_DW_LSB +: 3], dst_arr[g][1:0]);
      assign ch_step[g] = mv_step & (cur_reg == CW'(g));
    end
  endgenerate

  // Fixed priority: the lowest numbered pending channel gets the next element.
  always_comb begin
    pick_valid = 1'b0;
    pick_num   = '0;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (ch_pend[i]) begin
        pick_valid = 1'b1;
        pick_num   = CW'(i);
      end
    end
  end

  // A stopped controller starts no new element; one already under way is finished.
  assign start_next = gen_reg & pick_valid & ~mv_busy & ~start_reg & ~mv_step;
  assign cur_next   = start_next ? pick_num : cur_reg;

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      start_reg <= 1'b0;
      cur_reg   <= '0;
    end else begin
      start_reg <= start_next;
      cur_reg   <= cur_next;
    end
  end

  dma_mover u_mover (
    .i_clk_sys       (i_clk_sys),
    .i_rstn          (i_rstn),
    .i_start         (start_reg),
    .i_src           (src_arr[cur_reg]),
    .i_dst           (dst_arr[cur_reg]),
    .i_src_w         (ctrl_arr[cur_reg][`DMA_CTRL_SW_LSB +: 3]),
    .i_dst_w         (ctrl_arr[cur_reg][`DMA_CTRL_DW_LSB +: 3]),
    .i_m_readdata    (i_m_readdata),
    .i_m_waitrequest (i_m_waitrequest),
    .o_busy          (mv_busy),
    .o_step          (mv_step),
    .o_m_address     (o_m_address),
    .o_m_read        (o_m_read),
    .o_m_write       (o_m_write),
    .o_m_writedata   (o_m_writedata),
    .o_m_byteenable  (o_m_byteenable)
  );

  assign o_avs_readdata    = rdata_reg;
  assign o_avs_waitrequest = waitreq_reg;
  assign o_dma_enable      = gen_reg;
  assign o_ch_enable       = ch_en;

endmodule : dma_global_enable_and_channel_addresses
`default_nettype wire

/* File: sim/dma_addr_sva.sv */
/*
  Concurrent checks on the ports of the DMA top module.
  Assumes it is bound into that module, one clock domain and an active-low asynchronous reset.
*/
`timescale 1ns/1ps
`default_nettype none
`include "dma_map.svh"

module dma_addr_sva (
  input wire logic                   i_clk_sys,
  input wire logic                   i_rstn,
  input wire logic [`DMA_ADDR_W-1:0] i_avs_address,
  input wire logic                   i_avs_read,
  input wire logic                   i_avs_write,
  input wire logic [31:0]            i_avs_writedata,
  input wire logic [3:0]             i_avs_byteenable,
  input wire logic [31:0]            o_avs_readdata,
  input wire logic                   o_avs_waitrequest,
  input wire logic [31:0]            o_m_address,
  input wire logic                   o_m_read,
  input wire logic                   o_m_write,
  input wire logic [31:0]            o_m_writedata,
  input wire logic [3:0]             o_m_byteenable,
  input wire logic                   i_m_waitrequest,
  input wire logic                   o_dma_enable,
  input wire logic [`DMA_NUM_CH-1:0] o_ch_enable
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rstn);

  sequence taken_s;
    (i_avs_read || i_avs_write) && o_avs_waitrequest;
  endsequence
  sequence glb_write_s;
    taken_s ##0 (i_avs_write && i_avs_address == `DMA_GCFG_OFS && i_avs_byteenable[0]);
  endsequence
  sequence stopped_read_s;
    taken_s ##0 (i_avs_read && !o_dma_enable && i_avs_address != `DMA_GCFG_OFS);
  endsequence

  answer_one_wait_a: assert property (taken_s |=> !o_avs_waitrequest ##1 o_avs_waitrequest)
    else $error("register access not answered after one wait cycle");
  global_enable_write_a: assert property (glb_write_s |=> ##1 o_dma_enable == $past(i_avs_writedata[0]))
    else $error("global enable does not follow the written bit");
  stopped_read_zero_a: assert property (stopped_read_s |=> o_avs_readdata == 32'h00000000)
    else $error("read while stopped returned data");
  stopped_no_enable_a: assert property (!o_dma_enable && o_ch_enable == '0 |=> o_ch_enable == '0)
    else $error("channel enabled while controller stopped");
  mover_needs_enable_a: assert property ($rose(o_m_read) |->
    ($past(o_dma_enable) || $past(o_dma_enable, 2)) && ($past(|o_ch_enable) || $past(|o_ch_enable, 2)))
    else $error("element started without global and channel enable");
  read_then_write_a: assert property ($rose(o_m_write) |-> $past(o_m_read) || $past(o_m_read, 2))
    else $error("element write without preceding read");
  master_exclusive_a: assert property (!(o_m_read && o_m_write))
    else $error("master read and write together");
  master_hold_a: assert property ((o_m_read || o_m_write) && i_m_waitrequest |=>
    $stable({o_m_read, o_m_write, o_m_address, o_m_writedata, o_m_byteenable}))
    else $error("master request changed while stalled");
  word_aligned_a: assert property (o_m_read || o_m_write |-> o_m_address[1:0] == 2'h0)
    else $error("master address not word aligned");
endmodule : dma_addr_sva

bind dma_global_enable_and_channel_addresses dma_addr_sva dma_addr_sva_i (
  .i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
  .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable),
  .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest), .o_m_address(o_m_address),
  .o_m_read(o_m_read), .o_m_write(o_m_write), .o_m_writedata(o_m_writedata), .o_m_byteenable(o_m_byteenable),
  .i_m_waitrequest(i_m_waitrequest), .o_dma_enable(o_dma_enable), .o_ch_enable(o_ch_enable));
`default_nettype wire

/* File: sim/dma_mem_model.sv */
/*
  Memory slave behind the mover port, with random stalls and a record of the last accesses.
  Assumes an Avalon-MM master on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

module dma_mem_model (
  input  wire logic        i_clk_sys,
  input  wire logic        i_rstn,
  input  wire logic [31:0] i_address,
  input  wire logic        i_read,
  input  wire logic        i_write,
  input  wire logic [31:0] i_writedata,
  input  wire logic [3:0]  i_byteenable,
  output logic      [31:0] o_readdata,
  output logic             o_waitrequest,
  output logic      [31:0] o_last_rd,
  output logic      [31:0] o_last_wr,
  output logic      [31:0] o_last_data,
  output logic      [3:0]  o_last_be,
  output logic      [7:0]  o_wr_count
);
  logic [31:0] noise_reg;
  wire         answer = i_read && !o_waitrequest;

  // Outside an answer the data lines carry noise_reg, which negates itself each cycle and so stays zero from reset.
  assign o_readdata = answer ? (i_address ^ 32'h5a3c96e1) : noise_reg;

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      o_waitrequest <= 1'b1;
      noise_reg <= 32'h00000000;
      o_last_rd <= 32'h00000000;
      o_last_wr <= 32'h00000000;
      o_last_data <= 32'h00000000;
      o_last_be <= 4'h0;
      o_wr_count <= 8'h00;
    end else begin
      o_waitrequest <= ($urandom_range(0, 2) != 0);
      noise_reg <= ~noise_reg + 32'h00000001;
      if (answer) begin
        o_last_rd <= i_address;
      end
      if (i_write && !o_waitrequest) begin
        o_last_wr <= i_address;
        o_last_data <= i_writedata;
        o_last_be <= i_byteenable;
        o_wr_count <= o_wr_count + 8'h01;
      end
    end
  end
endmodule : dma_mem_model
`default_nettype wire

/* File: sim/test_dma_global_enable_and_channel_addresses.sv */
/*
  Self-checking bench for the DMA global enable and channel pointers.
  Assumes the design files, the memory model and the bound checker are compiled with it.
*/
`timescale 1ns/1ps
`default_nettype none
`include "dma_map.svh"

module test_dma_global_enable_and_channel_addresses;
  import dma_pkg::*;
  logic        i_clk_sys = 1'b0;
  logic        i_rstn = 1'b0;
  logic [11:0] i_avs_address = 12'h000;
  logic        i_avs_read = 1'b0;
  logic        i_avs_write = 1'b0;
  logic [31:0] i_avs_writedata = 32'h00000000;
  logic [3:0]  i_avs_byteenable = 4'hf;
  logic [31:0] o_avs_readdata, o_m_address, o_m_writedata, i_m_readdata;
  logic [31:0] last_rd, last_wr, last_data;
  logic        o_avs_waitrequest, o_m_read, o_m_write, i_m_waitrequest, o_dma_enable;
  logic [3:0]  o_m_byteenable, last_be;
  logic [1:0]  o_ch_enable;
  logic [7:0]  wr_count;
  int          failures = 0;
  int          comparisons = 0;
  int          seed;

  always #10 i_clk_sys = ~i_clk_sys;

  dma_global_enable_and_channel_addresses dma_global_enable_and_channel_addresses_i (
    .i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
    .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable),
    .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest), .o_m_address(o_m_address),
    .o_m_read(o_m_read), .o_m_write(o_m_write), .o_m_writedata(o_m_writedata), .o_m_byteenable(o_m_byteenable),
    .i_m_readdata(i_m_readdata), .i_m_waitrequest(i_m_waitrequest), .o_dma_enable(o_dma_enable),
    .o_ch_enable(o_ch_enable));

  dma_mem_model dma_mem_model_i (
    .i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_address(o_m_address), .i_read(o_m_read), .i_write(o_m_write),
    .i_writedata(o_m_writedata), .i_byteenable(o_m_byteenable), .o_readdata(i_m_readdata),
    .o_waitrequest(i_m_waitrequest), .o_last_rd(last_rd), .o_last_wr(last_wr), .o_last_data(last_data),
    .o_last_be(last_be), .o_wr_count(wr_count));

  task automatic wrap_up();
    if (failures == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : wrap_up

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      failures++;
    end
  endtask : check

  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
    int k;
    @(posedge i_clk_sys);
    i_avs_write <= wr;
    i_avs_read <= !wr;
    i_avs_address <= a;
    i_avs_writedata <= d;
    for (k = 0; k < 50; k++) begin
      @(posedge i_clk_sys);
      if (o_avs_waitrequest === 1'b0) break;
    end
    q = o_avs_readdata;
    i_avs_read <= 1'b0;
    i_avs_write <= 1'b0;
    if (k == 50) begin
      failures++;
      wrap_up();
    end
  endtask : bus

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h00000000, q);
    check(q, exp);
  endtask : rd

  function automatic logic [11:0] ra(input int ch, input logic [4:0] ofs);
    ra = {`DMA_CH_PAGE, 2'b00, ch[0], ofs};
  endfunction : ra

  function automatic logic [31:0] sz(input logic [2:0] w);
    sz = (w == 3'h2) ? 32'h4 : (w == 3'h1) ? 32'h2 : 32'h1;
  endfunction : sz

  function automatic logic [31:0] lanes(input logic [2:0] w, input logic [1:0] a);
    lanes = ((32'h1 << (8 * sz(w))) - 32'h1) << (8 * a);
  endfunction : lanes

  task automatic wait_idle(input int ch);
    int k;
    repeat (2) @(posedge i_clk_sys);
    for (k = 0; k < 400 && o_ch_enable[ch] !== 1'b0; k++) @(posedge i_clk_sys);
    if (k == 400) begin
      failures++;
      wrap_up();
    end
  endtask : wait_idle

  // One channel run with random aligned pointers, count and advance bits.
  task automatic xfer(input int ch, input logic [2:0] w);
    logic [31:0] s, d, n, si, di, sl, dl, e;
    logic [7:0]  base;
    n = $urandom_range(1, 4);
    si = $urandom_range(0, 1);
    di = $urandom_range(0, 1);
    s = $urandom & ~(sz(w) - 32'h1);
    d = $urandom & ~(sz(w) - 32'h1);
    base = wr_count;
    wr(ra(ch, `DMA_SRC_OFS), s);
    wr(ra(ch, `DMA_DST_OFS), d);
    wr(ra(ch, `DMA_CTRL_OFS), n | {w, 18'h0} | {w, 21'h0} | {si[0], 26'h0} | {di[0], 27'h0});
    wr(ra(ch, `DMA_SETUP_OFS), 32'h1);
    wait_idle(ch);
    sl = s + si * (n - 32'h1) * sz(w);
    dl = d + di * (n - 32'h1) * sz(w);
    e = (((sl & ~32'h3) ^ 32'h5a3c96e1) >> (8 * sl[1:0])) & lanes(w, 2'h0);
    check(last_rd, sl & ~32'h3);
    check(last_wr, dl & ~32'h3);
    check({28'h0, last_be}, {28'h0, 4'((32'h1 << sz(w)) - 32'h1) << dl[1:0]});
    check(last_data, e << (8 * dl[1:0]));
    check({24'h0, 8'(wr_count - base)}, n);
    rd(ra(ch, `DMA_SRC_OFS), s + si * n * sz(w));
    rd(ra(ch, `DMA_DST_OFS), d + di * n * sz(w));
  endtask : xfer

  initial begin
    int ch;
    int w;
    logic [31:0] v;
    seed = $urandom(59961);
    repeat (12) @(posedge i_clk_sys);
    i_rstn <= 1'b1;
    wr(ra(0, `DMA_SRC_OFS), 32'h12345678);
    rd(ra(0, `DMA_SRC_OFS), 32'h00000000);
    wr(`DMA_GCFG_OFS, 32'h00000001);
    rd(`DMA_GCFG_OFS, 32'h00000001);
    check({31'h0, o_dma_enable}, 32'h00000001);
    for (ch = 0; ch < 2; ch++) begin
      rd(ra(ch, `DMA_SRC_OFS), 32'h00000000);
      rd(ra(ch, `DMA_DST_OFS), 32'h00000000);
    end
    for (w = 0; w < 8; w++) begin
      ch = $urandom_range(0, 1);
      v = $urandom;
      wr(ra(ch, `DMA_SRC_OFS), v);
      rd(ra(ch, `DMA_SRC_OFS), v);
      wr(ra(ch, `DMA_DST_OFS), ~v);
      rd(ra(ch, `DMA_DST_OFS), ~v);
    end
    wr(12'h080, $urandom);
    rd(12'h080, 32'h00000000);
    for (w = 0; w < 3; w++) begin
      for (ch = 0; ch < 2; ch++) xfer(ch, 3'(w));
    end
    wr(`DMA_GCFG_OFS, 32'h00000000);
    wr(ra(1, `DMA_SETUP_OFS), 32'h00000001);
    @(posedge i_clk_sys);
    check({31'h0, o_ch_enable[1]}, 32'h00000000);
    check({31'h0, o_dma_enable}, 32'h00000000);
    rd(ra(1, `DMA_DST_OFS), 32'h00000000);
    wrap_up();
  end
endmodule : test_dma_global_enable_and_channel_addresses
`default_nettype wire
